// File: include/flow_tot_pkg.sv
package flow_tot_pkg;

   // time base
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned TICK_MS      = 100;
   localparam int unsigned PERSIST_S    = 1;
   localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned TICKS_PER_S  = 1000 / TICK_MS;
   localparam int unsigned PERSIST_SECS = PERSIST_S;
   localparam int          TB_W         = 20;
   localparam int          SUB_W        = 4;

   // setting limits
   localparam logic [11:0] MAX_DELAY_S  = 12'he10;
   localparam logic [15:0] FULL_SCALE   = 16'h03e8;

   // register byte offsets
   localparam logic [7:0] ADR_CTRL      = 8'h00;
   localparam logic [7:0] ADR_T1_START  = 8'h04;
   localparam logic [7:0] ADR_T1_ACTION = 8'h08;
   localparam logic [7:0] ADR_T1_PWR    = 8'h0c;
   localparam logic [7:0] ADR_T1_ARDLY  = 8'h10;
   localparam logic [7:0] ADR_T2_START  = 8'h14;
   localparam logic [7:0] ADR_T2_ACTION = 8'h18;
   localparam logic [7:0] ADR_T2_PWR    = 8'h1c;
   localparam logic [7:0] ADR_T1_COUNT  = 8'h20;
   localparam logic [7:0] ADR_T2_COUNT  = 8'h24;
   localparam logic [7:0] ADR_STATUS    = 8'h28;

   // control field positions
   localparam int CTRL_T1_EN   = 0;
   localparam int CTRL_T1_AUTO = 1;
   localparam int CTRL_T2_EN   = 2;
   localparam int CTRL_T2_DOWN = 3;
   localparam int CTRL_T1_CLR  = 4;
   localparam int CTRL_T2_CLR  = 5;
   localparam int CTRL_W       = 4;

   // reset values
   localparam logic [15:0] START_RST  = 16'h0000;
   localparam logic [31:0] ACTION_RST = 32'h0000_0000;
   localparam logic [11:0] DELAY_RST  = 12'h000;
   localparam logic [31:0] COUNT_RST  = 32'h0000_0000;

   typedef struct packed {
      logic decrement_direction;
      logic t2_en;
      logic t1_auto;
      logic t1_en;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '{default: 1'b0};

   typedef struct packed {
      logic restored;
      logic t2_active;
      logic t1_active;
      logic t2_event;
      logic t1_event;
   } status_t;

   typedef enum logic {
      ST_LOAD,
      ST_RUN
   } nv_state_t;

endpackage

// File: logic/tick_timebase.sv
`timescale 1ns/10ps
`default_nettype none
module tick_timebase
   import flow_tot_pkg::*;
#(
   parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // one-cycle pulses
   output logic      tick_o,
   output logic      sec_o
);

   logic [TB_W-1:0]  div_q;
   logic [SUB_W-1:0] sub_q;
   logic             div_end;
   logic             sub_end;

   assign div_end = (div_q == TB_W'(TICK_CYCLES_P - 1));
   assign sub_end = (sub_q == SUB_W'(TICKS_PER_S - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q  <= '0;
         sub_q  <= '0;
         tick_o <= 1'b0;
         sec_o  <= 1'b0;
      end else begin
         div_q  <= div_end ? '0 : div_q + 1'b1;
         tick_o <= div_end;
         sec_o  <= div_end && sub_end;
         if (div_end) begin
            sub_q <= sub_end ? '0 : sub_q + 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// File: logic/sec_delay.sv
`timescale 1ns/10ps
`default_nettype none
module sec_delay
   import flow_tot_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // control
   input  wire logic        arm_i,
   input  wire logic        sec_i,
   input  wire logic [11:0] delay_i,
   // status
   output logic             expired_o
);

   logic [11:0] cnt_q;

   // dropping arm restarts the wait from zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q     <= '0;
         expired_o <= 1'b0;
      end else if (!arm_i) begin
         cnt_q     <= '0;
         expired_o <= 1'b0;
      end else begin
         if (sec_i && (cnt_q < delay_i)) begin
            cnt_q <= cnt_q + 1'b1;
         end
         expired_o <= (cnt_q >= delay_i);
      end
   end

endmodule
`default_nettype wire

// File: logic/dual_flow_totalizer.sv
// Operation
// - each totalizer integrates flow rate over time, independent of the other
// - totalizer one value is written to nonvolatile storage every second
// - at power-up totalizer one starts from the last persisted value
// - totalizer one has an enable, disabled after reset
// - totalizer one counts only when flow is at or above its start threshold
// - totalizer one event when count >= nonzero action volume; zero disables
// - each totalizer waits its power-on delay, 0 to 3600 s, before counting
// - auto reset clears totalizer one on reaching action volume; default off
// - auto reset delay, 0 to 3600 s, postpones the automatic clear
// - a confirmed manual reset clears totalizer one at once
// - totalizer two is volatile and updated every 100 ms
// - totalizer two starts from zero after reset
// - totalizer two has its own enable, disabled after reset
// - totalizer two counts up or down, up after reset
// - counting down, totalizer two event when count reaches zero
// - counting up, totalizer two event when count >= nonzero action volume; zero disables
// - totalizer two counts only at or above its own start threshold
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dual_flow_totalizer
   import flow_tot_pkg::*;
#(
   parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // linearized flow rate, 0.1 %fs steps
   input  wire logic [15:0] flow_rate_i,
   // nonvolatile storage
   output logic             nv_rd_o,
   input  wire logic        nv_rd_valid_i,
   input  wire logic [31:0] nv_rd_data_i,
   output logic             nv_wr_o,
   output logic [31:0]      nv_wr_data_o,
   // totals and events
   output logic [31:0]      t1_count_o,
   output logic [31:0]      t2_count_o,
   output logic             t1_event_o,
   output logic             t2_event_o
);

   function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [15:0] b);
      logic [32:0] s;
      s = {1'b0, a} + {17'h0_0000, b};
      return s[32] ? 32'hffff_ffff : s[31:0];
   endfunction

   function automatic logic [31:0] sat_sub(input logic [31:0] a, input logic [15:0] b);
      logic [31:0] bb;
      bb = {16'h0000, b};
      return (a > bb) ? a - bb : 32'h0000_0000;
   endfunction

   function automatic logic [31:0] apply_sel(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [11:0] clamp_delay(input logic [31:0] v);
      return (v > {20'h0_0000, MAX_DELAY_S}) ? MAX_DELAY_S : v[11:0];
   endfunction

   function automatic logic [15:0] clamp_start(input logic [31:0] v);
      return (v > {16'h0000, FULL_SCALE}) ? FULL_SCALE : v[15:0];
   endfunction

   // configuration
   ctrl_t       ctrl_q;
   logic [15:0] t1_start_q;
   logic [31:0] t1_action_q;
   logic [11:0] t1_pwr_q;
   logic [11:0] t1_ardly_q;
   logic [15:0] t2_start_q;
   logic [31:0] t2_action_q;
   logic [11:0] t2_pwr_q;

   // state
   nv_state_t   nv_state_q;
   logic [31:0] t1_cnt_q;
   logic [31:0] t1_cnt_d;
   logic [31:0] t2_cnt_q;
   logic [31:0] t2_cnt_d;
   logic [11:0] up_secs_q;
   logic        t2_en_prev_q;
   logic        t1_event_q;
   logic        t2_event_q;
   logic        nv_wr_q;
   logic [31:0] nv_wr_data_q;
   logic        ack_q;
   logic [31:0] rd_q;

   // bus decode
   logic        bus_req;
   logic        wr_stb;
   logic        rd_stb;
   logic [31:0] wr_word;
   logic [31:0] rd_mux;
   logic        wr_ctrl;
   logic        clr1;
   logic        clr2;
   ctrl_t       ctrl_wr;

   // timing and gates
   logic        tick;
   logic        sec;
   logic        running;
   logic        t1_pwr_ok;
   logic        t2_pwr_ok;
   logic        t1_gate;
   logic        t2_gate;
   logic        t2_en_rise;
   logic        t1_reached;
   logic        t2_reached;
   logic        ar_arm;
   logic        ar_done;
   logic        nv_load;
   status_t     status;

   tick_timebase #(
      .TICK_CYCLES_P(TICK_CYCLES_P)
   ) u_timebase (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .tick_o(tick),
      .sec_o (sec)
   );

   // request taken once, answered on the next edge
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_stb  = bus_req && wb_we_i;
   assign rd_stb  = bus_req && !wb_we_i;
   assign wr_word = apply_sel(32'h0000_0000, wb_dat_i, wb_sel_i);
   assign wr_ctrl = wr_stb && (wb_adr_i == ADR_CTRL) && wb_sel_i[0];
   assign ctrl_wr = ctrl_t'(wb_dat_i[CTRL_W-1:0]);
   assign clr1    = wr_ctrl && wb_dat_i[CTRL_T1_CLR];
   assign clr2    = wr_ctrl && wb_dat_i[CTRL_T2_CLR];

   // read mux; unmapped offsets read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (wb_adr_i == ADR_CTRL) begin
         rd_mux[CTRL_W-1:0] = ctrl_q;
      end else if (wb_adr_i == ADR_T1_START) begin
         rd_mux[15:0] = t1_start_q;
      end else if (wb_adr_i == ADR_T1_ACTION) begin
         rd_mux = t1_action_q;
      end else if (wb_adr_i == ADR_T1_PWR) begin
         rd_mux[11:0] = t1_pwr_q;
      end else if (wb_adr_i == ADR_T1_ARDLY) begin
         rd_mux[11:0] = t1_ardly_q;
      end else if (wb_adr_i == ADR_T2_START) begin
         rd_mux[15:0] = t2_start_q;
      end else if (wb_adr_i == ADR_T2_ACTION) begin
         rd_mux = t2_action_q;
      end else if (wb_adr_i == ADR_T2_PWR) begin
         rd_mux[11:0] = t2_pwr_q;
      end else if (wb_adr_i == ADR_T1_COUNT) begin
         rd_mux = t1_cnt_q;
      end else if (wb_adr_i == ADR_T2_COUNT) begin
         rd_mux = t2_cnt_q;
      end else if (wb_adr_i == ADR_STATUS) begin
         rd_mux[4:0] = status;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rd_q  <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req;
         if (rd_stb) begin
            rd_q <= rd_mux;
         end
      end
   end

   // configuration registers; out-of-range settings saturate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q      <= CTRL_RST;
         t1_start_q  <= START_RST;
         t1_action_q <= ACTION_RST;
         t1_pwr_q    <= DELAY_RST;
         t1_ardly_q  <= DELAY_RST;
         t2_start_q  <= START_RST;
         t2_action_q <= ACTION_RST;
         t2_pwr_q    <= DELAY_RST;
      end else if (wr_stb) begin
         if (wr_ctrl) begin
            ctrl_q <= ctrl_wr;
         end else if (wb_adr_i == ADR_T1_START) begin
            t1_start_q <= clamp_start(apply_sel({16'h0000, t1_start_q}, wr_word, wb_sel_i));
         end else if (wb_adr_i == ADR_T1_ACTION) begin
            t1_action_q <= apply_sel(t1_action_q, wr_word, wb_sel_i);
         end else if (wb_adr_i == ADR_T1_PWR) begin
            t1_pwr_q <= clamp_delay(apply_sel({20'h0_0000, t1_pwr_q}, wr_word, wb_sel_i));
         end else if (wb_adr_i == ADR_T1_ARDLY) begin
            t1_ardly_q <= clamp_delay(apply_sel({20'h0_0000, t1_ardly_q}, wr_word, wb_sel_i));
         end else if (wb_adr_i == ADR_T2_START) begin
            t2_start_q <= clamp_start(apply_sel({16'h0000, t2_start_q}, wr_word, wb_sel_i));
         end else if (wb_adr_i == ADR_T2_ACTION) begin
            t2_action_q <= apply_sel(t2_action_q, wr_word, wb_sel_i);
         end else if (wb_adr_i == ADR_T2_PWR) begin
            t2_pwr_q <= clamp_delay(apply_sel({20'h0_0000, t2_pwr_q}, wr_word, wb_sel_i));
         end
      end
   end

   // seconds since power-up, saturating at the longest delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         up_secs_q <= 12'h000;
      end else if (sec && (up_secs_q < MAX_DELAY_S)) begin
         up_secs_q <= up_secs_q + 1'b1;
      end
   end

   assign t1_pwr_ok = (up_secs_q >= t1_pwr_q);
   assign t2_pwr_ok = (up_secs_q >= t2_pwr_q);

   // totalizer one stays idle until the stored total is back
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nv_state_q <= ST_LOAD;
      end else begin
         case (nv_state_q)
            ST_LOAD: begin
               if (nv_rd_valid_i) begin
                  nv_state_q <= ST_RUN;
               end
            end
            default: begin
               nv_state_q <= ST_RUN;
            end
         endcase
      end
   end

   assign running = (nv_state_q == ST_RUN);
   assign nv_load = (nv_state_q == ST_LOAD) && nv_rd_valid_i;

   assign t1_gate = running && ctrl_q.t1_en && t1_pwr_ok
                    && (flow_rate_i >= t1_start_q);
   assign t2_gate = ctrl_q.t2_en && t2_pwr_ok
                    && (flow_rate_i >= t2_start_q);

   assign t1_reached = (t1_action_q != 32'h0000_0000) && (t1_cnt_q >= t1_action_q);
   assign t2_reached = ctrl_q.decrement_direction
                       ? (ctrl_q.t2_en && (t2_cnt_q == 32'h0000_0000))
                       : ((t2_action_q != 32'h0000_0000) && (t2_cnt_q >= t2_action_q));

   assign ar_arm = running && ctrl_q.t1_auto && t1_reached;

   sec_delay u_ar_delay (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .arm_i    (ar_arm),
      .sec_i    (sec),
      .delay_i  (t1_ardly_q),
      .expired_o(ar_done)
   );

   // the restore wins over a clear issued before it arrives
   always_comb begin
      t1_cnt_d = t1_cnt_q;
      if (nv_load) begin
         t1_cnt_d = nv_rd_data_i;
      end else if (clr1 || ar_done) begin
         t1_cnt_d = COUNT_RST;
      end else if (tick && t1_gate) begin
         t1_cnt_d = sat_add(t1_cnt_q, flow_rate_i);
      end
   end

   assign t2_en_rise = ctrl_q.t2_en && !t2_en_prev_q;

   always_comb begin
      t2_cnt_d = t2_cnt_q;
      // a clear follows the direction written in the same word
      if (clr2) begin
         t2_cnt_d = ctrl_wr.decrement_direction ? t2_action_q : COUNT_RST;
      end else if (t2_en_rise && ctrl_q.decrement_direction) begin
         t2_cnt_d = t2_action_q;
      end else if (tick && t2_gate) begin
         t2_cnt_d = ctrl_q.decrement_direction
                    ? sat_sub(t2_cnt_q, flow_rate_i)
                    : sat_add(t2_cnt_q, flow_rate_i);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t1_cnt_q     <= COUNT_RST;
         t2_cnt_q     <= COUNT_RST;
         t2_en_prev_q <= 1'b0;
         t1_event_q   <= 1'b0;
         t2_event_q   <= 1'b0;
      end else begin
         t1_cnt_q     <= t1_cnt_d;
         t2_cnt_q     <= t2_cnt_d;
         t2_en_prev_q <= ctrl_q.t2_en;
         t1_event_q   <= t1_reached;
         t2_event_q   <= t2_reached;
      end
   end

   // persist once a second; the value written is the one held at that tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nv_wr_q      <= 1'b0;
         nv_wr_data_q <= COUNT_RST;
      end else begin
         nv_wr_q <= sec && running;
         if (sec && running) begin
            nv_wr_data_q <= t1_cnt_q;
         end
      end
   end

   assign status = '{restored:  running,
                     t2_active: t2_gate,
                     t1_active: t1_gate,
                     t2_event:  t2_event_q,
                     t1_event:  t1_event_q};

   assign wb_ack_o     = ack_q;
   assign wb_dat_o     = rd_q;
   assign nv_rd_o      = (nv_state_q == ST_LOAD);
   assign nv_wr_o      = nv_wr_q;
   assign nv_wr_data_o = nv_wr_data_q;
   assign t1_count_o   = t1_cnt_q;
   assign t2_count_o   = t2_cnt_q;
   assign t1_event_o   = t1_event_q;
   assign t2_event_o   = t2_event_q;

endmodule
`default_nettype wire

// File: test/flow_tot_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module flow_tot_asserts
   import flow_tot_pkg::*;
#(
   parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // flow and storage
   input wire logic [15:0] flow_rate_i,
   input wire logic        nv_rd_o,
   input wire logic        nv_rd_valid_i,
   input wire logic [31:0] nv_rd_data_i,
   input wire logic        nv_wr_o,
   // totals
   input wire logic [31:0] t1_count_o,
   input wire logic [31:0] t2_count_o,
   input wire logic        t1_event_o,
   input wire logic        t2_event_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] gap_q;
   logic        seen_q;
   wire         unmap = (wb_adr_i > ADR_STATUS) || (wb_adr_i[1:0] != 2'b00);
   // gap since the last persist write, so the period can be pinned exactly
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gap_q  <= '0;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= nv_wr_o ? 32'd1 : gap_q + 32'd1;
         seen_q <= seen_q | nv_wr_o;
      end
   end
   chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_unmapped_zero: assert property (wb_ack_o && $past(!wb_we_i && unmap) |-> wb_dat_o == '0)
      else $error("unmapped read not zero");
   chk_persist_period: assert property (nv_wr_o && seen_q |->
      gap_q == TICKS_PER_S * TICK_CYCLES_P)
      else $error("persist period wrong");
   chk_persist_after_load: assert property (nv_wr_o |-> !nv_rd_o)
      else $error("persist before restore");
   chk_restore_wait: assert property (nv_rd_o && !nv_rd_valid_i |=> nv_rd_o)
      else $error("restore left without data");
   chk_restore_load: assert property (nv_rd_o && nv_rd_valid_i |=>
      !nv_rd_o && t1_count_o == $past(nv_rd_data_i))
      else $error("restored value not loaded");
   chk_reset_state: assert property ($fell(rst_i) |->
      nv_rd_o && t2_count_o == '0 && !t2_event_o)
      else $error("state after reset wrong");
   chk_t1_event_nonzero: assert property (t1_event_o |-> $past(t1_count_o) != '0)
      else $error("event with zero count");
   chk_t1_step: assert property ((t1_count_o > $past(t1_count_o)) && !$past(nv_rd_o) |->
      (t1_count_o - $past(t1_count_o) == {16'h0000, $past(flow_rate_i)}) ||
      (t1_count_o - $past(t1_count_o) == {16'h0000, $past(flow_rate_i, 2)}))
      else $error("count step differs from flow");
endmodule
bind dual_flow_totalizer flow_tot_asserts #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flow_rate_i(flow_rate_i),
   .nv_rd_o(nv_rd_o), .nv_rd_valid_i(nv_rd_valid_i), .nv_rd_data_i(nv_rd_data_i),
   .nv_wr_o(nv_wr_o), .t1_count_o(t1_count_o), .t2_count_o(t2_count_o),
   .t1_event_o(t1_event_o), .t2_event_o(t2_event_o));
`default_nettype wire

// File: test/nv_store_model.sv
`timescale 1ns/10ps
`default_nettype none
module nv_store_model #(
   parameter logic [31:0] RESTORE_V = 32'h0000_0100,
   parameter int          LAT       = 5
) (
   // clock and reset
   input wire logic         clk_i,
   input wire logic         rst_i,
   // storage port
   input wire logic         nv_rd_i,
   input wire logic         nv_wr_i,
   input wire logic [31:0]  nv_wr_data_i,
   output logic             nv_rd_valid_o,
   output logic [31:0]      nv_rd_data_o,
   // bench view
   output logic [31:0]      last_wr_o,
   output int               wr_cnt_o
);
   logic [3:0] wait_q;
   // storage survives reset, as nonvolatile cells do
   initial last_wr_o = RESTORE_V;
   initial wr_cnt_o = 0;
   always @(posedge clk_i) begin
      wait_q <= (rst_i || !nv_rd_i) ? 4'h0 : (wait_q == 4'hf ? wait_q : wait_q + 4'h1);
      if (nv_wr_i) begin
         last_wr_o <= nv_wr_data_i;
         wr_cnt_o  <= wr_cnt_o + 1;
      end
   end
   assign nv_rd_valid_o = nv_rd_i && !rst_i && (wait_q == LAT[3:0]);
   // data shows garbage outside the valid cycle
   assign nv_rd_data_o = nv_rd_valid_o ? last_wr_o : ~last_wr_o;
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import flow_tot_pkg::*;
   localparam logic [31:0] RESTORE_V = 32'h0000_0100;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, nv_rd_data_i, nv_wr_data_o, t1_count_o, t2_count_o;
   logic [31:0] last_wr, rd_q, v;
   logic [15:0] flow_rate_i;
   logic        nv_rd_o, nv_rd_valid_i, nv_wr_o, t1_event_o, t2_event_o;
   int          fail_count, num_checks, wr_cnt, w;
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   dual_flow_totalizer #(.TICK_CYCLES_P(10)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .flow_rate_i(flow_rate_i), .nv_rd_o(nv_rd_o), .nv_rd_valid_i(nv_rd_valid_i),
      .nv_rd_data_i(nv_rd_data_i), .nv_wr_o(nv_wr_o), .nv_wr_data_o(nv_wr_data_o),
      .t1_count_o(t1_count_o), .t2_count_o(t2_count_o), .t1_event_o(t1_event_o),
      .t2_event_o(t2_event_o));
   nv_store_model #(.RESTORE_V(RESTORE_V)) nv_u (.clk_i(clk_i), .rst_i(rst_i),
      .nv_rd_i(nv_rd_o), .nv_wr_i(nv_wr_o), .nv_wr_data_i(nv_wr_data_o),
      .nv_rd_valid_o(nv_rd_valid_i), .nv_rd_data_o(nv_rd_data_i), .last_wr_o(last_wr),
      .wr_cnt_o(wr_cnt));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask
   task automatic chk1(input string nm, input logic c);
      check(nm, 32'h1, {31'h0, c});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // one classic cycle; released only at the edge that sees ack
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         check("bus ack", 32'h1, 32'h0);
         end_of_test();
      end
      rd_q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask
   // 0 restore done, 1 t1 event, 2 t2 event, 3 t1 below v
   task automatic wait_for(input int which, input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(posedge clk_i);
         if (which == 0 && nv_rd_o === 1'b0) break;
         if (which == 1 && t1_event_o === 1'b1) break;
         if (which == 2 && t2_event_o === 1'b1) break;
         if (which == 3 && t1_count_o < v) break;
      end
      if (n == lim) begin
         check("wait", which, 32'hffff_ffff);
         end_of_test();
      end
   endtask
   task automatic test_power_on();
      check("t2 after reset", 32'h0, t2_count_o);
      wait_for(0, 50);
      check("t1 restored", RESTORE_V, t1_count_o);
      wb(1'b0, ADR_CTRL, 32'h0);
      check("ctrl default", 32'h0, rd_q);
      wb(1'b0, ADR_T1_ACTION, 32'h0);
      check("action default", 32'h0, rd_q);
      wb(1'b0, 8'h2c, 32'h0);
      check("unmapped read", 32'h0, rd_q);
      wb(1'b0, ADR_STATUS, 32'h0);
      check("status restored", 32'h10, rd_q);
      wb(1'b1, ADR_T2_PWR, 32'h5);
      flow_rate_i <= 16'd20;
      wb(1'b1, ADR_CTRL, 32'h4);
      cyc(300);
      check("t2 in delay", 32'h0, t2_count_o);
      cyc(400);
      chk1("t2 counts up", t2_count_o > 0 && t2_count_o % 20 == 0);
      check("t1 disabled", RESTORE_V, t1_count_o);
      $display("test power_on done");
   endtask
   task automatic test_t1_gate();
      wb(1'b1, ADR_T1_START, 32'h0000_ffff);
      wb(1'b0, ADR_T1_START, 32'h0);
      check("start clamp", {16'h0, FULL_SCALE}, rd_q);
      wb(1'b1, ADR_T1_START, 32'd100);
      flow_rate_i <= 16'd50;
      wb(1'b1, ADR_CTRL, 32'h5);
      cyc(200);
      check("t1 below start", RESTORE_V, t1_count_o);
      flow_rate_i <= 16'd100;
      v = t1_count_o;
      cyc(200);
      w = t1_count_o - v;
      chk1("t1 integrates", w % 100 == 0 && w >= 1800 && w <= 2200);
      $display("test t1_gate done");
   endtask
   task automatic test_t1_event_auto();
      v = t1_count_o + 32'd1000;
      wb(1'b1, ADR_T1_ACTION, v);
      wb(1'b1, ADR_T1_ARDLY, 32'h2);
      wb(1'b1, ADR_CTRL, 32'h7);
      chk1("t1 event early", t1_event_o === 1'b0);
      wait_for(1, 300);
      chk1("t1 at action", t1_count_o >= v);
      cyc(80);
      chk1("auto clear held", t1_count_o >= v);
      wait_for(3, 300);
      wb(1'b1, ADR_CTRL, 32'h5);
      wb(1'b1, ADR_T1_ACTION, 32'h0);
      cyc(3);
      check("zero action", 32'h0, t1_event_o);
      $display("test t1_event_auto done");
   endtask
   task automatic test_clear_persist();
      wb(1'b1, ADR_CTRL, 32'h4);
      w = wr_cnt;
      cyc(250);
      check("persisted", t1_count_o, last_wr);
      chk1("persist rate", wr_cnt - w >= 2);
      wb(1'b1, ADR_CTRL, 32'h14);
      check("manual clear", 32'h0, t1_count_o);
      $display("test clear_persist done");
   endtask
   task automatic test_t2_modes();
      v = t2_count_o + 32'd500;
      wb(1'b1, ADR_T2_ACTION, v);
      wait_for(2, 300);
      chk1("t2 up event", t2_count_o >= v);
      wb(1'b1, ADR_T2_ACTION, 32'd800);
      wb(1'b1, ADR_CTRL, 32'h2c);
      cyc(2);
      chk1("t2 loaded", t2_count_o >= 700 && t2_count_o <= 800);
      check("t2 down no event", 32'h0, t2_event_o);
      wait_for(2, 300);
      check("t2 at zero", 32'h0, t2_count_o);
      wb(1'b1, ADR_T2_START, 32'd200);
      wb(1'b1, ADR_CTRL, 32'h2c);
      cyc(200);
      check("t2 below start", 32'd800, t2_count_o);
      $display("test t2_modes done");
   endtask
   task automatic test_reset_again();
      wb(1'b1, ADR_CTRL, 32'h1);
      cyc(250);
      wb(1'b1, ADR_CTRL, 32'h0);
      cyc(120);
      v = t1_count_o;
      rst_i <= 1'b1;
      cyc(4);
      rst_i <= 1'b0;
      wait_for(0, 50);
      check("t1 survives", v, t1_count_o);
      check("t2 lost", 32'h0, t2_count_o);
      $display("test reset_again done");
   endtask
   initial begin
      rst_i       = 1'b1;
      wb_cyc_i    = 1'b0;
      wb_stb_i    = 1'b0;
      wb_we_i     = 1'b0;
      wb_adr_i    = 8'h00;
      wb_sel_i    = 4'hf;
      wb_dat_i    = 32'h0;
      flow_rate_i = 16'h0;
      fail_count  = 0;
      num_checks  = 0;
      cyc(4);
      rst_i <= 1'b0;
      cyc(1);
      test_power_on();
      test_t1_gate();
      test_t1_event_auto();
      test_clear_persist();
      test_t2_modes();
      test_reset_again();
      end_of_test();
   end
   initial begin
      #9_000_000;
      check("run time", 32'h0, 32'h1);
      end_of_test();
   end
endmodule
`default_nettype wire
